// File: aovs_top.sv
// Analog output value selector: setpoints, scaling and fault values.
// Assumes synchronous inputs; meas_done pulses once per measurement.
//
// Behaviour
// - Voltage high 0.1-10 V, default 10 V
// - Reject voltage pair closer than 1 V
// - Voltage low 0-9.9 V, default 0 V
// - Teach 30/31 set voltage high 5/10 V
// - Teach 30/31 force voltage low 0 V
// - Current high 2.2-20 mA, default 20 mA
// - Reject current pair closer than 2 mA
// - Current low 2-19.9 mA, default 4 mA
// - Clamp to endpoint setpoint outside window
// - Voltage power-up low/high until first measurement
// - Current power-up low/high until first measurement
// - Voltage no-target low/high/hold, default hold
// - Current no-target low/high/hold, default hold
// - No-target delay continuous, 5 ms steps
// - Voltage sync-loss low/high/hold, default hold
// - Current sync-loss low/high/hold, default hold
// - One sync-loss delay, default 0
// - Shared settings apply to both outputs
// - Linear scaling between window endpoints
`timescale 1ns/1ps
module aovs_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_wr_v,
  input wire logic [aovs_pkg::VW-1:0] cfg_v_lo,
  input wire logic [aovs_pkg::VW-1:0] cfg_v_hi,
  input wire logic cfg_wr_i,
  input wire logic [aovs_pkg::IW-1:0] cfg_i_lo,
  input wire logic [aovs_pkg::IW-1:0] cfg_i_hi,
  input wire logic teach_stb,
  input wire logic [7:0] teach_code,
  input wire logic pwrup_v_high,
  input wire logic pwrup_i_high,
  input wire logic [1:0] notgt_act_v,
  input wire logic [1:0] notgt_act_i,
  input wire logic [1:0] nosync_act_v,
  input wire logic [1:0] nosync_act_i,
  input wire logic [aovs_pkg::DLY_W-1:0] notgt_delay,
  input wire logic [aovs_pkg::DLY_W-1:0] nosync_delay,
  input wire logic [aovs_pkg::DIST_W-1:0] win_lo_dist,
  input wire logic [aovs_pkg::DIST_W-1:0] win_hi_dist,
  input wire logic sync_follower,
  input wire logic sync_pulse,
  input wire logic meas_done,
  input wire logic meas_valid,
  input wire logic [aovs_pkg::DIST_W-1:0] meas_dist,
  output logic [aovs_pkg::VW-1:0] v_out,
  output logic [aovs_pkg::IW-1:0] i_out,
  output logic cfg_reject,
  output logic [aovs_pkg::VW-1:0] v_lo_sp,
  output logic [aovs_pkg::VW-1:0] v_hi_sp,
  output logic [aovs_pkg::IW-1:0] i_lo_sp,
  output logic [aovs_pkg::IW-1:0] i_hi_sp
);
  localparam int VW = aovs_pkg::VW;
  localparam int DW = aovs_pkg::DIST_W;
  localparam int FW = aovs_pkg::FRAC_W;
  default clocking aovs_cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Linear interpolation lo + (hi-lo)*frac
  function automatic logic [7:0] lerp(input logic [7:0] lo,
    input logic [7:0] hi, input logic [FW-1:0] frac);
    logic [FW+8:0] prod;
    logic [8:0] diff;
    logic up;
    logic [7:0] delta;
    up = hi >= lo;
    diff = up ? {1'b0, hi - lo} : {1'b0, lo - hi};
    prod = diff * frac;
    delta = prod[FW+7:FW];
    lerp = up ? lo + delta : lo - delta;
  endfunction : lerp

  // Fault action selection
  function automatic logic [7:0] pick(input logic [1:0] act,
    input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] cur);
    pick = act == aovs_pkg::ACT_LOW ? lo :
      act == aovs_pkg::ACT_HIGH ? hi : cur;
  endfunction : pick

  typedef enum logic [1:0] {AOVS_PWRUP, AOVS_RUN} aovs_state_t;
  aovs_state_t st_reg;
  aovs_state_t st_next;

  logic [VW-1:0] v_lo_reg;
  logic [VW-1:0] v_hi_reg;
  logic [VW-1:0] i_lo_reg;
  logic [VW-1:0] i_hi_reg;
  logic [VW-1:0] v_out_reg;
  logic [VW-1:0] i_out_reg;
  logic rej_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic sync_lost_reg;

  wire logic v_hi_ok = cfg_v_hi >= aovs_pkg::V_HI_MIN &&
    cfg_v_hi <= aovs_pkg::V_HI_MAX;
  wire logic v_lo_ok = cfg_v_lo <= aovs_pkg::V_LO_MAX;
  wire logic v_gap_ok = cfg_v_hi >= cfg_v_lo &&
    (cfg_v_hi - cfg_v_lo) >= aovs_pkg::V_GAP_MIN;
  wire logic v_acc = v_hi_ok && v_lo_ok && v_gap_ok;
  wire logic i_hi_ok = cfg_i_hi >= aovs_pkg::I_HI_MIN &&
    cfg_i_hi <= aovs_pkg::I_HI_MAX;
  wire logic i_lo_ok = cfg_i_lo >= aovs_pkg::I_LO_MIN &&
    cfg_i_lo <= aovs_pkg::I_LO_MAX;
  wire logic i_gap_ok = cfg_i_hi >= cfg_i_lo &&
    (cfg_i_hi - cfg_i_lo) >= aovs_pkg::I_GAP_MIN;
  wire logic i_acc = i_hi_ok && i_lo_ok && i_gap_ok;

  wire logic t30 = teach_stb && teach_code == aovs_pkg::TEACH_V5;
  wire logic t31 = teach_stb && teach_code == aovs_pkg::TEACH_V10;

  wire logic [VW-1:0] v_hi_next = t30 ? aovs_pkg::V_TEACH30 :
    t31 ? aovs_pkg::V_TEACH31 :
    (cfg_wr_v && v_acc) ? cfg_v_hi : v_hi_reg;
  wire logic [VW-1:0] v_lo_next = (t30 || t31) ? aovs_pkg::V_LO_RST :
    (cfg_wr_v && v_acc) ? cfg_v_lo : v_lo_reg;
  wire logic [VW-1:0] i_hi_next = (cfg_wr_i && i_acc) ? cfg_i_hi : i_hi_reg;
  wire logic [VW-1:0] i_lo_next = (cfg_wr_i && i_acc) ? cfg_i_lo : i_lo_reg;
  wire logic rej_next = (cfg_wr_v && !v_acc && !t30 && !t31) ||
    (cfg_wr_i && !i_acc);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      v_lo_reg <= aovs_pkg::V_LO_RST;
      v_hi_reg <= aovs_pkg::V_HI_RST;
      i_lo_reg <= aovs_pkg::I_LO_RST;
      i_hi_reg <= aovs_pkg::I_HI_RST;
      rej_reg <= 1'b0;
    end else begin
      v_lo_reg <= v_lo_next;
      v_hi_reg <= v_hi_next;
      i_lo_reg <= i_lo_next;
      i_hi_reg <= i_hi_next;
      rej_reg <= rej_next;
    end
  end

  // 5 ms tick generator
  wire logic tick_wrap = tick_cnt_reg == 32'(aovs_pkg::TICK_CYC - 1);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + 32'h1;
      tick_reg <= tick_wrap;
    end
  end

  // Fault timers; sync presence tracked from pulses
  logic notgt_seen_reg;
  wire logic notgt_level = meas_done ? !meas_valid : notgt_seen_reg;
  wire logic notgt_exp;
  wire logic nosync_exp;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) notgt_seen_reg <= 1'b0;
    else notgt_seen_reg <= notgt_level;
  end

  aovs_delay u_notgt (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(tick_reg),
    .fault(notgt_level),
    .delay(notgt_delay),
    .expired(notgt_exp)
  );

  aovs_delay u_nosync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(tick_reg),
    .fault(sync_follower && !sync_pulse),
    .delay(nosync_delay),
    .expired(nosync_exp)
  );
  wire logic sync_lost_next = nosync_exp && !sync_lost_reg ? 1'b1 :
    (sync_pulse || !sync_follower) ? 1'b0 : sync_lost_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) sync_lost_reg <= 1'b0;
    else sync_lost_reg <= sync_lost_next;
  end

  // Window position; clamp, linear
  wire logic inc = win_hi_dist >= win_lo_dist;
  wire logic [DW-1:0] span = inc ? win_hi_dist - win_lo_dist :
    win_lo_dist - win_hi_dist;
  wire logic [DW-1:0] off = inc ? meas_dist - win_lo_dist :
    win_lo_dist - meas_dist;
  wire logic below = inc ? meas_dist <= win_lo_dist :
    meas_dist >= win_lo_dist;
  wire logic above = inc ? meas_dist >= win_hi_dist :
    meas_dist <= win_hi_dist;
  wire logic [DW+FW-1:0] quot = span == '0 ? '0 :
    {off, {FW{1'b0}}} / {{FW{1'b0}}, span};
  wire logic [FW-1:0] frac = quot[FW-1:0];
  wire logic [VW-1:0] v_lin = above ? v_hi_reg : below ? v_lo_reg :
    lerp(v_lo_reg, v_hi_reg, frac);
  wire logic [VW-1:0] i_lin = above ? i_hi_reg : below ? i_lo_reg :
    lerp(i_lo_reg, i_hi_reg, frac);

  // power-up value held until first result
  wire logic [VW-1:0] v_pwr = pwrup_v_high ? v_hi_reg : v_lo_reg;
  wire logic [VW-1:0] i_pwr = pwrup_i_high ? i_hi_reg : i_lo_reg;

  wire logic [VW-1:0] v_flt = sync_lost_reg ?
    pick(nosync_act_v, v_lo_reg, v_hi_reg, v_out_reg) :
    pick(notgt_act_v, v_lo_reg, v_hi_reg, v_out_reg);
  wire logic [VW-1:0] i_flt = sync_lost_reg ?
    pick(nosync_act_i, i_lo_reg, i_hi_reg, i_out_reg) :
    pick(notgt_act_i, i_lo_reg, i_hi_reg, i_out_reg);
  wire logic fault_on = sync_lost_reg || notgt_exp;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      AOVS_PWRUP: if (meas_done) st_next = AOVS_RUN;
      AOVS_RUN: st_next = AOVS_RUN;
      default: st_next = AOVS_PWRUP;
    endcase
  end

  wire logic upd = meas_done && meas_valid && !sync_lost_reg;
  wire logic [VW-1:0] v_out_next = st_reg == AOVS_PWRUP && !meas_done ?
    v_pwr : upd ? v_lin : fault_on ? v_flt : v_out_reg;
  wire logic [VW-1:0] i_out_next = st_reg == AOVS_PWRUP && !meas_done ?
    i_pwr : upd ? i_lin : fault_on ? i_flt : i_out_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= AOVS_PWRUP;
      v_out_reg <= aovs_pkg::V_LO_RST;
      i_out_reg <= aovs_pkg::I_LO_RST;
    end else begin
      st_reg <= st_next;
      v_out_reg <= v_out_next;
      i_out_reg <= i_out_next;
    end
  end

  assign v_out = v_out_reg;
  assign i_out = i_out_reg;
  assign cfg_reject = rej_reg;
  assign v_lo_sp = v_lo_reg;
  assign v_hi_sp = v_hi_reg;
  assign i_lo_sp = i_lo_reg;
  assign i_hi_sp = i_hi_reg;

  // Assertions
  sequence s_teach;
    teach_stb && (teach_code == aovs_pkg::TEACH_V5 ||
      teach_code == aovs_pkg::TEACH_V10);
  endsequence
  sequence s_lost_meas;
    sync_lost_reg && meas_done;
  endsequence
  sequence s_notgt_meas;
    meas_done && !meas_valid && notgt_exp && !sync_lost_reg;
  endsequence
  AST_TEACH_LO: assert property (
    s_teach |=> v_lo_reg == aovs_pkg::V_LO_RST)
    else $error("teach did not clear voltage low");
  AST_TEACH30: assert property (
    teach_stb && teach_code == aovs_pkg::TEACH_V5 |=>
      v_hi_reg == aovs_pkg::V_TEACH30)
    else $error("teach 30 wrong high");
  AST_TEACH31: assert property (
    teach_stb && teach_code == aovs_pkg::TEACH_V10 |=>
      v_hi_reg == aovs_pkg::V_TEACH31)
    else $error("teach 31 wrong high");
  AST_VGAP: assert property (
    v_hi_reg >= v_lo_reg &&
      v_hi_reg - v_lo_reg >= aovs_pkg::V_GAP_MIN)
    else $error("voltage gap too small");
  AST_IGAP: assert property (
    i_hi_reg >= i_lo_reg + aovs_pkg::I_GAP_MIN)
    else $error("current gap too small");
  AST_VREJ: assert property (
    cfg_wr_v && !v_acc && !t30 && !t31 |=>
      cfg_reject && v_lo_reg == $past(v_lo_reg) &&
      v_hi_reg == $past(v_hi_reg))
    else $error("bad voltage pair not refused");
  AST_IREJ: assert property (
    cfg_wr_i && !i_acc |=>
      cfg_reject && i_lo_reg == $past(i_lo_reg) &&
      i_hi_reg == $past(i_hi_reg))
    else $error("bad current pair not refused");
  AST_VHI_RANGE: assert property (
    v_hi_reg >= aovs_pkg::V_HI_MIN && v_hi_reg <= aovs_pkg::V_HI_MAX)
    else $error("voltage high out of range");
  AST_VLO_RANGE: assert property (
    v_lo_reg <= aovs_pkg::V_LO_MAX)
    else $error("voltage low out of range");
  AST_IHI_RANGE: assert property (
    i_hi_reg >= aovs_pkg::I_HI_MIN && i_hi_reg <= aovs_pkg::I_HI_MAX)
    else $error("current high out of range");
  AST_ILO_RANGE: assert property (
    i_lo_reg >= aovs_pkg::I_LO_MIN && i_lo_reg <= aovs_pkg::I_LO_MAX)
    else $error("current low out of range");
  AST_CLAMP: assert property (
    upd && above && !teach_stb && !cfg_wr_v |=> v_out == v_hi_reg)
    else $error("voltage not clamped high");
  AST_CLAMP_LO: assert property (
    upd && below && !above && !teach_stb && !cfg_wr_v |=>
      v_out == v_lo_reg)
    else $error("voltage not clamped low");
  AST_PWRUP: assert property (
    !sys_rst && st_reg == AOVS_PWRUP && !meas_done && !pwrup_v_high |=>
      v_out == $past(v_lo_reg))
    else $error("power-up voltage wrong");
  AST_IPWRUP: assert property (
    !sys_rst && st_reg == AOVS_PWRUP && !meas_done && pwrup_i_high |=>
      i_out == $past(i_hi_reg))
    else $error("power-up current wrong");
  AST_NOTGT_V: assert property (
    s_notgt_meas ##0 notgt_act_v == aovs_pkg::ACT_HIGH |=>
      v_out == $past(v_hi_reg))
    else $error("no-target voltage not high");
  AST_NOTGT_I: assert property (
    s_notgt_meas ##0 notgt_act_i == aovs_pkg::ACT_LOW |=>
      i_out == $past(i_lo_reg))
    else $error("no-target current not low");
  AST_NOSYNC_V: assert property (
    s_lost_meas ##0 nosync_act_v == aovs_pkg::ACT_LOW |=>
      v_out == $past(v_lo_reg))
    else $error("sync-loss voltage not low");
  AST_NOSYNC_I: assert property (
    s_lost_meas ##0 nosync_act_i == aovs_pkg::ACT_HIGH |=>
      i_out == $past(i_hi_reg))
    else $error("sync-loss current not high");
  AST_SYNC_LOST: assert property (
    sync_lost_reg && sync_pulse |=> !sync_lost_reg)
    else $error("sync pulse did not clear loss");
endmodule : aovs_top

// File: aovs_pkg.sv
// Package: constants for the analog output value selector.
// Assumes a 40 MHz system clock; values are in setpoint step units.
package aovs_pkg;
  // Voltage in 50 mV steps, current in 0.1 mA steps
  localparam int VW = 8;
  localparam int IW = 8;
  localparam logic [VW-1:0] V_STEP_MV = 8'h32;
  localparam logic [VW-1:0] V_HI_MIN = 8'h02;
  localparam logic [VW-1:0] V_HI_MAX = 8'hc8;
  localparam logic [VW-1:0] V_LO_MAX = 8'hc6;
  localparam logic [VW-1:0] V_HI_RST = 8'hc8;
  localparam logic [VW-1:0] V_LO_RST = 8'h00;
  localparam logic [VW-1:0] V_GAP_MIN = 8'h14;
  localparam logic [VW-1:0] V_TEACH30 = 8'h64;
  localparam logic [VW-1:0] V_TEACH31 = 8'hc8;
  localparam logic [IW-1:0] I_HI_MIN = 8'h16;
  localparam logic [IW-1:0] I_HI_MAX = 8'hc8;
  localparam logic [IW-1:0] I_LO_MIN = 8'h14;
  localparam logic [IW-1:0] I_LO_MAX = 8'hc7;
  localparam logic [IW-1:0] I_HI_RST = 8'hc8;
  localparam logic [IW-1:0] I_LO_RST = 8'h28;
  localparam logic [IW-1:0] I_GAP_MIN = 8'h14;
  // Teach codes
  localparam logic [7:0] TEACH_V5 = 8'h1e;
  localparam logic [7:0] TEACH_V10 = 8'h1f;
  // Fault action codes
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  // Delay tick: 5 ms at 40 MHz
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 5;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int DLY_W = 16;
  localparam int DIST_W = 16;
  localparam int FRAC_W = 16;
endpackage : aovs_pkg

// File: aovs_delay.sv
// Delay timer: counts continuous fault time in 5 ms ticks.
// Assumes a tick strobe shared by all timers.
`timescale 1ns/1ps
module aovs_delay (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic fault,
  input wire logic [aovs_pkg::DLY_W-1:0] delay,
  output logic expired
);
  logic [aovs_pkg::DLY_W:0] cnt_reg;
  logic [aovs_pkg::DLY_W:0] cnt_next;
  wire logic at_end = cnt_reg > {1'b0, delay};
  assign cnt_next = !fault ? '0 :
    (tick && !at_end) ? cnt_reg + 1'b1 : cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) cnt_reg <= '0;
    else cnt_reg <= cnt_next;
  end
  // Zero delay expires at once on a fault
  assign expired = fault && (delay == '0 || at_end);
endmodule : aovs_delay

// File: aovs_drv_model.sv
// Partner model: voltage and current-loop output drivers.
// Assumes codes in 50 mV and 0.1 mA steps from the selector.
`timescale 1ns/1ps
module aovs_drv_model (
  input wire logic [aovs_pkg::VW-1:0] v_code,
  input wire logic [aovs_pkg::IW-1:0] i_code,
  output int v_mv,
  output int i_ua
);
  // Output levels follow the codes
  always_comb begin
    v_mv = int'(v_code) * int'(aovs_pkg::V_STEP_MV);
    i_ua = int'(i_code) * 100;
  end
endmodule : aovs_drv_model

// File: analog_output_value_selector_tb.sv
// Testbench: bench model against the value selector.
// Assumes aovs_pkg, aovs_top and aovs_drv_model compiled first.
`timescale 1ns/1ps
module analog_output_value_selector_tb;
  logic clk_sys, sys_rst, cfg_wr_v, cfg_wr_i, teach_stb, cfg_reject;
  logic pwrup_v_high, pwrup_i_high, sync_follower, sync_pulse;
  logic meas_done, meas_valid;
  logic [7:0] cfg_v_lo, cfg_v_hi, cfg_i_lo, cfg_i_hi, teach_code;
  logic [7:0] v_out, i_out, v_lo_sp, v_hi_sp, i_lo_sp, i_hi_sp;
  logic [1:0] notgt_act_v, notgt_act_i, nosync_act_v, nosync_act_i;
  logic [15:0] notgt_delay, nosync_delay, win_lo_dist, win_hi_dist;
  logic [15:0] meas_dist;
  logic [31:0] seed;
  int vlo, vhi, ilo, ihi, vo, io, rej, lost, lav, lai, wl, wh;
  int miscompares, total_checks, cyc, v_mv, i_ua, k;

  aovs_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr_v(cfg_wr_v),
    .cfg_v_lo(cfg_v_lo), .cfg_v_hi(cfg_v_hi), .cfg_wr_i(cfg_wr_i),
    .cfg_i_lo(cfg_i_lo), .cfg_i_hi(cfg_i_hi), .teach_stb(teach_stb),
    .teach_code(teach_code), .pwrup_v_high(pwrup_v_high),
    .pwrup_i_high(pwrup_i_high), .notgt_act_v(notgt_act_v),
    .notgt_act_i(notgt_act_i), .nosync_act_v(nosync_act_v),
    .nosync_act_i(nosync_act_i), .notgt_delay(notgt_delay),
    .nosync_delay(nosync_delay), .win_lo_dist(win_lo_dist),
    .win_hi_dist(win_hi_dist), .sync_follower(sync_follower),
    .sync_pulse(sync_pulse), .meas_done(meas_done),
    .meas_valid(meas_valid), .meas_dist(meas_dist), .v_out(v_out),
    .i_out(i_out), .cfg_reject(cfg_reject), .v_lo_sp(v_lo_sp),
    .v_hi_sp(v_hi_sp), .i_lo_sp(i_lo_sp), .i_hi_sp(i_hi_sp));
  aovs_drv_model drv (.v_code(v_out), .i_code(i_out), .v_mv(v_mv),
    .i_ua(i_ua));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int scale(int lo, int hi, int d);
    int n, m;
    n = d - wl;
    m = wh - wl;
    if (m < 0) begin
      n = -n;
      m = -m;
    end
    if (n <= 0) return lo;
    if (n >= m) return hi;
    return lo + (hi - lo) * n / m;
  endfunction : scale

  function automatic int act(int a, int cur, int lo, int hi);
    return (a == 1) ? lo : (a == 2) ? hi : cur;
  endfunction : act

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic fire(input bit outs);
    @(posedge clk_sys);
    cfg_wr_v <= 1'h0;
    cfg_wr_i <= 1'h0;
    teach_stb <= 1'h0;
    meas_done <= 1'h0;
    sync_pulse <= 1'h0;
    #1;
    check("v_lo_sp", v_lo_sp, vlo);
    check("v_hi_sp", v_hi_sp, vhi);
    check("i_lo_sp", i_lo_sp, ilo);
    check("i_hi_sp", i_hi_sp, ihi);
    check("cfg_reject", cfg_reject, rej);
    if (outs) begin
      check("v_out", v_out, vo);
      check("i_out", i_out, io);
      check("v_mv", v_mv, vo * 50);
      check("i_ua", i_ua, io * 100);
    end
  endtask : fire

  task automatic do_reset(input bit pv, input bit pi);
    @(posedge clk_sys);
    sys_rst <= 1'h1;
    pwrup_v_high <= pv;
    pwrup_i_high <= pi;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'h0;
    vlo = 0;
    vhi = 'hc8;
    ilo = 'h28;
    ihi = 'hc8;
    vo = pv ? vhi : vlo;
    io = pi ? ihi : ilo;
    rej = 0;
    fire(1'b1);
  endtask : do_reset

  task automatic wr(input bit cur, input int lo, input int hi);
    @(posedge clk_sys);
    if (cur) begin
      cfg_i_lo <= 8'(lo);
      cfg_i_hi <= 8'(hi);
      cfg_wr_i <= 1'h1;
      rej = !(lo >= 'h14 && lo <= 'hc7 && hi >= 'h16 && hi <= 'hc8 &&
        hi >= lo + 'h14);
      if (!rej) {ilo, ihi} = {lo, hi};
    end else begin
      cfg_v_lo <= 8'(lo);
      cfg_v_hi <= 8'(hi);
      cfg_wr_v <= 1'h1;
      rej = !(lo <= 'hc6 && hi >= 'h02 && hi <= 'hc8 && hi >= lo + 'h14);
      if (!rej) {vlo, vhi} = {lo, hi};
    end
    fire(1'b0);
  endtask : wr

  task automatic teach(input int code);
    @(posedge clk_sys);
    teach_code <= 8'(code);
    teach_stb <= 1'h1;
    if (code == 'h1e || code == 'h1f) begin
      vhi = (code == 'h1e) ? 'h64 : 'hc8;
      vlo = 0;
    end
    rej = 0;
    fire(1'b0);
  endtask : teach

  task automatic meas(input bit ok, input int d, input int av, input int ai);
    @(posedge clk_sys);
    meas_valid <= ok;
    meas_dist <= 16'(d);
    meas_done <= 1'h1;
    notgt_act_v <= 2'(av);
    notgt_act_i <= 2'(ai);
    if (lost) begin
      vo = act(lav, vo, vlo, vhi);
      io = act(lai, io, ilo, ihi);
    end else if (ok) begin
      vo = scale(vlo, vhi, d);
      io = scale(ilo, ihi, d);
    end else if (notgt_delay == 16'h0000) begin
      vo = act(av, vo, vlo, vhi);
      io = act(ai, io, ilo, ihi);
    end
    fire(1'b1);
  endtask : meas

  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      complete_run;
    end
  end

  initial begin
    {sys_rst, cfg_wr_v, cfg_wr_i, teach_stb, pwrup_v_high} = 5'h10;
    {pwrup_i_high, sync_follower, sync_pulse, meas_done} = 4'h0;
    {meas_valid, cfg_v_lo, cfg_v_hi, cfg_i_lo, cfg_i_hi} = 33'h0;
    {teach_code, notgt_act_v, notgt_act_i, nosync_act_v} = 14'h0;
    {nosync_act_i, notgt_delay, nosync_delay, meas_dist} = 50'h0;
    seed = 32'h0000_0013;
    {lost, wl, wh} = {32'h0, 32'h0000_03e8, 32'h0000_07d0};
    win_lo_dist = 16'h03e8;
    win_hi_dist = 16'h07d0;
    do_reset(1'b0, 1'b0);
    wr(0, 'h10, 'h23);
    wr(0, 'h10, 'h24);
    wr(0, 'hc7, 'hc8);
    wr(0, 'h00, 'h01);
    wr(1, 'h13, 'h30);
    wr(1, 'h28, 'h3b);
    wr(1, 'h28, 'h3c);
    wr(1, 'h14, 'hc9);
    for (k = 0; k < 12; k++) begin
      wr(k[0], int'(rnd() % 210), int'(rnd() % 210));
    end
    wr(1, 'h28, 'hc8);
    // teach codes and an unknown code
    wr(0, 'h20, 'ha0);
    teach('h1e);
    wr(0, 'h20, 'ha0);
    teach('h1f);
    teach('h07);
    for (k = 0; k < 30; k++) begin
      meas(rnd() % 3 != 0, 1000 + (int'(rnd() % 13) - 2) * 125,
        int'(rnd() % 4), int'(rnd() % 4));
    end
    @(posedge clk_sys);
    {win_lo_dist, win_hi_dist} <= {16'h07d0, 16'h03e8};
    {wl, wh} = {32'h0000_07d0, 32'h0000_03e8};
    meas(1, 1250, 0, 0);
    // delay not yet expired keeps value
    @(posedge clk_sys);
    notgt_delay <= 16'h0001;
    meas(0, 0, 1, 2);
    repeat (40) @(posedge clk_sys);
    meas(0, 0, 1, 2);
    @(posedge clk_sys);
    sync_follower <= 1'h1;
    {nosync_act_v, nosync_act_i} <= 4'h6;
    {lost, lav, lai} = {32'h1, 32'h1, 32'h2};
    meas(1, 1500, 0, 0);
    meas(1, 1900, 0, 0);
    @(posedge clk_sys);
    sync_pulse <= 1'h1;
    fire(1'b1);
    @(posedge clk_sys);
    sync_follower <= 1'h0;
    nosync_delay <= 16'h0001;
    lost = 0;
    repeat (3) @(posedge clk_sys);
    meas(1, 1500, 0, 0);
    @(posedge clk_sys);
    sync_follower <= 1'h1;
    sync_pulse <= 1'h1;
    fire(1'b1);
    meas(1, 1250, 0, 0);
    do_reset(1'b1, 1'b1);
    complete_run;
  end
endmodule : analog_output_value_selector_tb
